// ===== logic/flow_pkg.sv
// constants and carrier types shared by the program-flow sequencer
package flow_pkg;
	// =====================================================================
	// widths
	localparam int PC_W_MAX = 18;
	localparam int STACK_DEPTH = 8;
	localparam int SIDX_W = 4;
	localparam int IRQ_N = 6;
	localparam int ADDR_FIELD_W = 13;
	localparam int BANK_W = 5;
	// =====================================================================
	// vectors
	localparam logic [PC_W_MAX-1:0] RESET_VEC = 18'h0_0000;
	localparam logic [PC_W_MAX-1:0] VEC_EXT = 18'h0_0004;
	localparam logic [PC_W_MAX-1:0] VEC_TMR0 = 18'h0_0008;
	localparam logic [PC_W_MAX-1:0] VEC_TMR1 = 18'h0_000C;
	localparam logic [PC_W_MAX-1:0] VEC_TMR2 = 18'h0_0010;
	localparam logic [PC_W_MAX-1:0] VEC_RCOSC = 18'h0_0014;
	localparam logic [PC_W_MAX-1:0] VEC_ADPCM = 18'h0_0018;
	localparam logic [4:0] LAST_PAGE_MID = 5'h1F;
	localparam logic [7:0] TBL_HIGH_RST = 8'h00;
	localparam logic [SIDX_W-1:0] SIDX_RST = 4'h0;
	localparam logic [SIDX_W-1:0] SIDX_FULL = 4'h8;
	// =====================================================================
	// operation codes presented by the decoder
	typedef enum logic [3:0] {
		OP_SEQ = 4'b0000,
		OP_SKIP = 4'b0001,
		OP_PCL_WR = 4'b0010,
		OP_JUMP = 4'b0011,
		OP_CALL = 4'b0100,
		OP_RET = 4'b0101,
		OP_ISR_EXIT = 4'b0110,
		OP_TBL_CUR = 4'b0111,
		OP_TBL_LAST = 4'b1000,
		OP_ALU = 4'b1001
	} flow_op_t;
	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_DUMMY = 2'b01,
		ST_TABLE = 2'b10
	} flow_state_t;
	// =====================================================================
	// carriers
	typedef struct packed {
		flow_op_t op;
		logic [ADDR_FIELD_W-1:0] addr;
		logic [7:0] data;
	} flow_cmd_t;
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] mid;
		logic [7:0] high;
	} table_ptr_t;
	typedef struct packed {
		logic [7:0] result;
		logic carry;
		logic aux_carry;
		logic zero;
		logic overflow;
	} alu_res_t;
endpackage : flow_pkg

// ===== logic/return_stack.sv
// eight-entry return-address stack with registered read data
`timescale 1ns/100ps
`default_nettype none
module return_stack (
	// clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_arst_n,
	// push and pop
	input  wire logic                          i_push,
	input  wire logic                          i_pop,
	input  wire logic [flow_pkg::PC_W_MAX-1:0] i_wdata,
	// state
	output logic      [flow_pkg::PC_W_MAX-1:0] o_top,
	output logic      [flow_pkg::SIDX_W-1:0]   o_count
);
	import flow_pkg::*;
	logic [PC_W_MAX-1:0] mem_q [STACK_DEPTH];
	logic [SIDX_W-1:0]   count_q;
	logic [2:0]          wr_slot;
	logic [2:0]          top_slot;
	logic [2:0]          next_top;
	assign wr_slot  = count_q[2:0];
	assign top_slot = 3'(count_q - 4'h1);
	assign next_top = i_push ? wr_slot : (i_pop ? 3'(count_q - 4'h2) : top_slot);
	assign o_count  = count_q;
	// =====================================================================
	// storage, overflow wraps onto the oldest entry
	always_ff @(posedge i_clk) begin
		if (i_push) begin
			mem_q[wr_slot] <= i_wdata;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_q <= SIDX_RST;
		end else if (i_push && count_q != SIDX_FULL) begin
			count_q <= count_q + 4'h1;
		end else if (i_pop && count_q != SIDX_RST) begin
			count_q <= count_q - 4'h1;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_top <= RESET_VEC;
		end else if (i_push) begin
			o_top <= i_wdata;
		end else if (i_pop) begin
			o_top <= mem_q[next_top];
		end
	end
endmodule : return_stack
`default_nettype wire

// ===== logic/program_flow_sequencer.sv
// program counter, stack, interrupt vectoring and table reads
`timescale 1ns/100ps
`default_nettype none
// Operation
// - pc width parameter 18, 17, 16, 15
// - low byte write keeps upper pc bits
// - jump or call: field plus bank pointer
// - returns restore pc from stack top
// - stack full: flag kept, acknowledge withheld
// - pop lets withheld interrupt be served
// - call executes even when stack full
// - alu result and status written back
// - fetch starts at address zero after reset
// - external falling edge vectors to 004H
// - timer 0 overflow vectors to 008H
// - timer 1 overflow vectors to 00CH
// - timer 2 overflow vectors to 010H
// - rc converter request vectors to 014H
// - adpcm request vectors to 018H
// - table address from three pointer registers
// - current table address bit mapping
// - last page: mid bits all ones
// - table low byte out, high byte kept
// - table high byte changes only by reads
// - table reads take two cycles
// - eight level hidden stack, empty at reset
// - push pc at call and acknowledge
// - non-sequential flow inserts one dummy cycle
module program_flow_sequencer #(
	parameter int PC_W = 18
) (
	// clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_arst_n,
	// instruction-cycle enable and decoded command
	input  wire logic                          i_cyc_en,
	input  wire flow_pkg::flow_cmd_t           i_cmd,
	input  wire logic                          i_skip_taken,
	input  wire logic [7:0]                    i_bank_ptr,
	input  wire flow_pkg::table_ptr_t          i_tbl_ptr,
	// alu result to write back
	input  wire flow_pkg::alu_res_t            i_alu,
	// interrupt sources and enables
	input  wire logic                          i_ext_int_n,
	input  wire logic                          i_tmr0_ovf,
	input  wire logic                          i_tmr1_ovf,
	input  wire logic                          i_tmr2_ovf,
	input  wire logic                          i_rcosc_irq,
	input  wire logic                          i_adpcm_irq,
	input  wire logic [flow_pkg::IRQ_N-1:0]    i_irq_en,
	input  wire logic                          i_global_en,
	// program rom
	output logic      [flow_pkg::PC_W_MAX-1:0] o_rom_addr,
	input  wire logic [15:0]                   i_rom_data,
	// state and results
	output logic      [flow_pkg::PC_W_MAX-1:0] o_pc,
	output logic      [7:0]                    o_pc_low_byte,
	output logic      [7:0]                    o_table_high_byte,
	output logic      [7:0]                    o_table_low_byte,
	output logic                               o_table_low_valid,
	output logic      [7:0]                    o_dest_data,
	output logic      [3:0]                    o_status,
	output logic                               o_dest_we,
	output logic                               o_fetch_valid,
	output logic                               o_int_ack,
	output logic      [flow_pkg::IRQ_N-1:0]    o_irq_flags,
	output logic                               o_stack_full
);
	import flow_pkg::*;
	// =====================================================================
	// width mask
	function automatic logic [PC_W_MAX-1:0] PC_MAX_MASK();
		logic [PC_W_MAX-1:0] m;
		m = '0;
		for (int i = 0; i < PC_W_MAX; i++) begin
			m[i] = (i < PC_W) && (PC_W >= 15) && (PC_W <= 18);
		end
		return m;
	endfunction : PC_MAX_MASK
	localparam logic [PC_W_MAX-1:0] PC_MASK = PC_MAX_MASK();
	// =====================================================================
	// registers
	logic [PC_W_MAX-1:0] pc_q;
	logic [PC_W_MAX-1:0] pc_d;
	flow_state_t         state_q;
	flow_state_t         state_d;
	logic [IRQ_N-1:0]    flags_q;
	logic [IRQ_N-1:0]    flags_d;
	logic                in_isr_q;
	logic [7:0]          tbl_high_q;
	logic [PC_W_MAX-1:0] tbl_addr_q;
	logic                ext_prev_q;
	// =====================================================================
	// stack
	logic [PC_W_MAX-1:0] stk_top;
	logic [SIDX_W-1:0]   stk_count;
	logic                push;
	logic                pop;
	logic                stack_full;
	assign stack_full = (stk_count == SIDX_FULL);
	return_stack u_stack (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_push   (push),
		.i_pop    (pop),
		.i_wdata  (pc_q),
		.o_top    (stk_top),
		.o_count  (stk_count)
	);
	// =====================================================================
	// decode
	wire exec       = i_cyc_en && (state_q == ST_EXEC);
	wire op_call    = exec && (i_cmd.op == OP_CALL);
	wire op_jump    = exec && (i_cmd.op == OP_JUMP);
	wire op_ret     = exec && (i_cmd.op == OP_RET);
	wire op_isr_exit    = exec && (i_cmd.op == OP_ISR_EXIT);
	wire op_pcl     = exec && (i_cmd.op == OP_PCL_WR);
	wire op_skip    = exec && (i_cmd.op == OP_SKIP) && i_skip_taken;
	wire op_tbl_cur = exec && (i_cmd.op == OP_TBL_CUR);
	wire op_tbl_lst = exec && (i_cmd.op == OP_TBL_LAST);
	wire op_alu     = exec && (i_cmd.op == OP_ALU);
	wire op_tbl     = op_tbl_cur || op_tbl_lst;
	// =====================================================================
	// interrupt requests, lowest vector first
	wire [IRQ_N-1:0] irq_evt = {i_adpcm_irq, i_rcosc_irq, i_tmr2_ovf, i_tmr1_ovf, i_tmr0_ovf,
		ext_prev_q && !i_ext_int_n};
	wire [IRQ_N-1:0] irq_pend = flags_q & i_irq_en;
	wire [IRQ_N-1:0] irq_pick = irq_pend & (~irq_pend + 6'h01);
	wire             irq_take = exec && i_global_en && !in_isr_q && (irq_pend != 6'h00)
		&& !stack_full
		&& !op_call && !op_ret && !op_isr_exit && !op_tbl;
	logic [PC_W_MAX-1:0] irq_vec;
	always_comb begin
		irq_vec = VEC_ADPCM;
		if (irq_pick[0]) begin
			irq_vec = VEC_EXT;
		end else if (irq_pick[1]) begin
			irq_vec = VEC_TMR0;
		end else if (irq_pick[2]) begin
			irq_vec = VEC_TMR1;
		end else if (irq_pick[3]) begin
			irq_vec = VEC_TMR2;
		end else if (irq_pick[4]) begin
			irq_vec = VEC_RCOSC;
		end
	end
	// flag set wins over acknowledge clear
	assign flags_d = (flags_q & ~(irq_take ? irq_pick : 6'h00)) | irq_evt;
	// =====================================================================
	// stack control
	assign push = op_call || irq_take;
	assign pop  = op_ret || op_isr_exit;
	// =====================================================================
	// sequential, skip, jump, low byte and table addresses
	wire [PC_W_MAX-1:0] pc_seq    = (pc_q + 18'h0_0001) & PC_MASK;
	wire [PC_W_MAX-1:0] tbl_cur_a = {i_tbl_ptr.high[1:0], i_tbl_ptr.mid, i_tbl_ptr.low};
	wire [PC_W_MAX-1:0] tbl_lst_a = {i_bank_ptr[BANK_W-1:0], LAST_PAGE_MID, i_tbl_ptr.low};
	wire [PC_W_MAX-1:0] jmp_a     = {i_bank_ptr[BANK_W-1:0], i_cmd.addr};
	wire [PC_W_MAX-1:0] pcl_a     = {pc_q[PC_W_MAX-1:8], i_cmd.data};
	wire [PC_W_MAX-1:0] skip_a    = (pc_q + 18'h0_0002) & PC_MASK;
	// =====================================================================
	// next pc and sequencing
	always_comb begin
		pc_d    = pc_q;
		state_d = state_q;
		if (i_cyc_en) begin
			case (state_q)
				ST_EXEC: begin
					if (irq_take) begin
						pc_d    = irq_vec;
						state_d = ST_DUMMY;
					end else if (op_call || op_jump) begin
						pc_d    = jmp_a & PC_MASK;
						state_d = ST_DUMMY;
					end else if (op_ret || op_isr_exit) begin
						pc_d    = stk_top & PC_MASK;
						state_d = ST_DUMMY;
					end else if (op_pcl) begin
						pc_d    = pcl_a & PC_MASK;
						state_d = ST_DUMMY;
					end else if (op_skip) begin
						pc_d    = skip_a;
						state_d = ST_DUMMY;
					end else if (op_tbl) begin
						state_d = ST_TABLE;
					end else begin
						pc_d = pc_seq;
					end
				end
				ST_DUMMY: begin
					state_d = ST_EXEC;
				end
				ST_TABLE: begin
					pc_d    = pc_seq;
					state_d = ST_EXEC;
				end
				default: begin
					state_d = ST_EXEC;
				end
			endcase
		end
	end
	// =====================================================================
	// state registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pc_q    <= RESET_VEC;
			state_q <= ST_EXEC;
		end else begin
			pc_q    <= pc_d;
			state_q <= state_d;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flags_q    <= 6'h00;
			ext_prev_q <= 1'b1;
		end else begin
			flags_q    <= flags_d;
			ext_prev_q <= i_ext_int_n;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			in_isr_q <= 1'b0;
		end else if (irq_take) begin
			in_isr_q <= 1'b1;
		end else if (op_isr_exit) begin
			in_isr_q <= 1'b0;
		end
	end
	// =====================================================================
	// table read: address in first cycle, data in second
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tbl_addr_q <= RESET_VEC;
		end else if (op_tbl) begin
			tbl_addr_q <= (op_tbl_cur ? tbl_cur_a : tbl_lst_a) & PC_MASK;
		end
	end
	wire tbl_done = i_cyc_en && (state_q == ST_TABLE);
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tbl_high_q        <= TBL_HIGH_RST;
			o_table_low_byte  <= 8'h00;
			o_table_low_valid <= 1'b0;
		end else begin
			o_table_low_valid <= tbl_done;
			if (tbl_done) begin
				tbl_high_q       <= i_rom_data[15:8];
				o_table_low_byte <= i_rom_data[7:0];
			end
		end
	end
	// =====================================================================
	// alu write back
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_dest_data <= 8'h00;
			o_status    <= 4'h0;
			o_dest_we   <= 1'b0;
		end else begin
			o_dest_we <= op_alu;
			if (op_alu) begin
				o_dest_data <= i_alu.result;
				o_status    <= {i_alu.overflow, i_alu.zero, i_alu.aux_carry, i_alu.carry};
			end
		end
	end
	// =====================================================================
	// outputs
	assign o_rom_addr        = (state_q == ST_TABLE) ? tbl_addr_q : pc_q;
	assign o_pc              = pc_q;
	assign o_pc_low_byte     = pc_q[7:0];
	assign o_table_high_byte = tbl_high_q;
	assign o_fetch_valid     = (state_q == ST_EXEC);
	assign o_int_ack         = irq_take;
	assign o_irq_flags       = flags_q;
	assign o_stack_full      = stack_full;
endmodule : program_flow_sequencer
`default_nettype wire

// ===== verification/rom_model.sv
// behavioural program rom answering every address with a coded word
`timescale 1ns/100ps
`default_nettype none
module rom_model (
	// fetch address and word
	input  wire logic [flow_pkg::PC_W_MAX-1:0] i_addr,
	output logic      [15:0]                   o_data
);
	// bits 17:16 fold into bits 1:0, so addresses differing only in bits 17:16 give distinct words
	assign o_data = {i_addr[7:0] ^ 8'h3C, i_addr[15:8] ^ {6'h00, i_addr[17:16]}};
endmodule : rom_model
`default_nettype wire

// ===== verification/flow_checker.sv
// concurrent checks on the program-flow sequencer ports
`timescale 1ns/100ps
`default_nettype none
module flow_checker #(
	parameter int PC_W = 18
) (
	// watched ports
	input wire logic                          i_clk,
	input wire logic                          i_arst_n,
	input wire logic                          i_cyc_en,
	input wire flow_pkg::flow_cmd_t           i_cmd,
	input wire logic [7:0]                    i_bank_ptr,
	input wire flow_pkg::table_ptr_t          i_tbl_ptr,
	input wire flow_pkg::alu_res_t            i_alu,
	input wire logic [flow_pkg::IRQ_N-1:0]    i_irq_en,
	input wire logic [flow_pkg::PC_W_MAX-1:0] o_rom_addr,
	input wire logic [flow_pkg::PC_W_MAX-1:0] o_pc,
	input wire logic [7:0]                    o_table_high_byte,
	input wire logic [7:0]                    o_dest_data,
	input wire logic [3:0]                    o_status,
	input wire logic                          o_dest_we,
	input wire logic                          o_fetch_valid,
	input wire logic                          o_int_ack,
	input wire logic [flow_pkg::IRQ_N-1:0]    o_irq_flags,
	input wire logic                          o_stack_full
);
	import flow_pkg::*;
	localparam logic [17:0] PC_M = 18'h3_FFFF >> (PC_W_MAX - PC_W);
	logic        tk;
	logic [5:0]  pend;
	logic [17:0] vsel, p_q, v_q, tc_q, tl_q;
	flow_cmd_t   c_q;
	logic [7:0]  b_q;
	alu_res_t    a_q;
	assign tk = i_cyc_en && o_fetch_valid && !o_int_ack;
	assign pend = o_irq_flags & i_irq_en;
	assign vsel = pend[0] ? VEC_EXT : pend[1] ? VEC_TMR0 : pend[2] ? VEC_TMR1 :
		pend[3] ? VEC_TMR2 : pend[4] ? VEC_RCOSC : VEC_ADPCM;
	always_ff @(posedge i_clk) begin
		c_q <= i_cmd;
		b_q <= i_bank_ptr;
		p_q <= o_pc;
		a_q <= i_alu;
		v_q <= vsel;
		tc_q <= {i_tbl_ptr.high[1:0], i_tbl_ptr.mid, i_tbl_ptr.low};
		tl_q <= {i_bank_ptr[4:0], LAST_PAGE_MID, i_tbl_ptr.low};
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	// =====================================================================
	// assertions
	chk_reset_start: assert property ($rose(i_arst_n) |-> o_pc == RESET_VEC && !o_stack_full)
		else $error("pc or stack not clear after reset");
	chk_jump_load: assert property (tk && i_cmd.op inside {OP_JUMP, OP_CALL}
		|=> o_pc == ({b_q[4:0], c_q.addr} & PC_M)) else $error("jump target wrong");
	chk_pcl_keep: assert property (tk && i_cmd.op == OP_PCL_WR
		|=> o_pc == ({p_q[17:8], c_q.data} & PC_M)) else $error("low byte write wrong");
	chk_dummy_ins: assert property (tk && i_cmd.op inside {OP_JUMP, OP_CALL, OP_RET, OP_ISR_EXIT, OP_PCL_WR}
		|=> !o_fetch_valid) else $error("no dummy cycle");
	chk_table_cur: assert property (tk && i_cmd.op == OP_TBL_CUR
		|=> !o_fetch_valid && o_rom_addr == tc_q) else $error("table address wrong");
	chk_table_last: assert property (tk && i_cmd.op == OP_TBL_LAST
		|=> !o_fetch_valid && o_rom_addr == tl_q) else $error("last page address wrong");
	chk_ack_vector: assert property (o_int_ack |=> o_pc == (v_q & PC_M))
		else $error("vector wrong");
	chk_full_hold: assert property (o_stack_full |-> !o_int_ack)
		else $error("ack while stack full");
	chk_ack_dummy: assert property (o_int_ack |=> !o_fetch_valid && !o_int_ack)
		else $error("ack not followed by dummy");
	chk_high_keep: assert property (o_fetch_valid |=> $stable(o_table_high_byte))
		else $error("table high byte changed");
	chk_alu_back: assert property (tk && i_cmd.op == OP_ALU |=> o_dest_we && o_dest_data == a_q.result
		&& o_status == {a_q.overflow, a_q.zero, a_q.aux_carry, a_q.carry}) else $error("alu write wrong");
	cov_ack: cover property (o_int_ack);
	cov_full: cover property (o_stack_full && i_cyc_en);
	cov_last: cover property (tk && i_cmd.op == OP_TBL_LAST);
endmodule : flow_checker
bind program_flow_sequencer flow_checker #(.PC_W(PC_W)) u_chk (.i_clk, .i_arst_n, .i_cyc_en, .i_cmd,
	.i_bank_ptr, .i_tbl_ptr, .i_alu, .i_irq_en, .o_rom_addr, .o_pc, .o_table_high_byte, .o_dest_data,
	.o_status, .o_dest_we, .o_fetch_valid, .o_int_ack, .o_irq_flags, .o_stack_full);
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the program-flow sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
	import flow_pkg::*;
	localparam logic [17:0] VECS [6] = '{VEC_EXT, VEC_TMR0, VEC_TMR1, VEC_TMR2, VEC_RCOSC, VEC_ADPCM};
	logic i_clk = 0, i_arst_n = 0, i_cyc_en = 1, i_skip_taken = 0, i_ext_int_n = 1, i_global_en = 1;
	logic i_tmr0_ovf = 0, i_tmr1_ovf = 0, i_tmr2_ovf = 0, i_rcosc_irq = 0, i_adpcm_irq = 0;
	logic [7:0] i_bank_ptr = 8'h13;
	logic [5:0] i_irq_en = 6'h3F;
	flow_cmd_t i_cmd = '0;
	table_ptr_t i_tbl_ptr = '{8'h5A, 8'hB3, 8'h02};
	alu_res_t i_alu = '{8'hC3, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [15:0] i_rom_data;
	logic [17:0] o_rom_addr, o_pc, pcs;
	logic [7:0] o_pc_low_byte, o_table_high_byte, o_table_low_byte, o_dest_data;
	logic [5:0] o_irq_flags;
	logic [3:0] o_status;
	logic o_table_low_valid, o_dest_we, o_fetch_valid, o_int_ack, o_stack_full;
	int fails = 0, n_checks = 0;
	program_flow_sequencer #(.PC_W(18)) u_dut (.i_clk, .i_arst_n, .i_cyc_en, .i_cmd, .i_skip_taken,
		.i_bank_ptr, .i_tbl_ptr, .i_alu, .i_ext_int_n, .i_tmr0_ovf, .i_tmr1_ovf, .i_tmr2_ovf, .i_rcosc_irq,
		.i_adpcm_irq, .i_irq_en, .i_global_en, .o_rom_addr, .i_rom_data, .o_pc, .o_pc_low_byte,
		.o_table_high_byte, .o_table_low_byte, .o_table_low_valid, .o_dest_data, .o_status, .o_dest_we,
		.o_fetch_valid, .o_int_ack, .o_irq_flags, .o_stack_full);
	rom_model u_rom (.i_addr(o_rom_addr), .o_data(i_rom_data));
	initial forever #10 i_clk = ~i_clk;
	initial begin
		repeat (20000) @(posedge i_clk);
		fails++;
		final_report();
	end
	// =====================================================================
	// shared tasks
	task automatic final_report();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic cmp(input string nm, input logic [17:0] e, input logic [17:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : cmp
	task automatic issue(input flow_op_t op, input logic [12:0] a, input logic [7:0] d, input logic sk = 1'b0);
		@(posedge i_clk);
		i_cmd <= '{op, a, d};
		i_skip_taken <= sk;
		@(negedge i_clk);
		while (o_fetch_valid !== 1'b1) @(negedge i_clk);
		pcs = o_pc;
		@(posedge i_clk);
		i_cmd <= '0;
		i_skip_taken <= 1'b0;
		#1;
	endtask : issue
	task automatic pulse(input logic [5:0] m);
		@(posedge i_clk);
		{i_adpcm_irq, i_rcosc_irq, i_tmr2_ovf, i_tmr1_ovf, i_tmr0_ovf, i_ext_int_n} <= m ^ 6'h01;
		@(posedge i_clk);
		{i_adpcm_irq, i_rcosc_irq, i_tmr2_ovf, i_tmr1_ovf, i_tmr0_ovf, i_ext_int_n} <= 6'h01;
	endtask : pulse
	task automatic ack(input logic [17:0] v, input logic want);
		logic seen;
		seen = 1'b0;
		for (int k = 0; k < 8 && !seen; k++) begin
			@(negedge i_clk);
			seen = (o_int_ack === 1'b1);
		end
		cmp("int_ack", want, seen);
		if (seen) begin
			@(posedge i_clk);
			#1;
			cmp("vector", v, o_pc);
		end
	endtask : ack
	task automatic tbl(input flow_op_t op, input logic [17:0] a);
		logic [15:0] w;
		w = {a[7:0] ^ 8'h3C, a[15:8] ^ {6'h00, a[17:16]}};
		issue(op, 13'h0000, 8'h00);
		@(negedge i_clk);
		cmp("tbl_addr", a, o_rom_addr);
		cmp("fetch", 0, o_fetch_valid);
		for (int k = 0; k < 4 && o_table_low_valid !== 1'b1; k++) @(negedge i_clk);
		cmp("low_valid", 1, o_table_low_valid);
		cmp("low", w[7:0], o_table_low_byte);
		cmp("high", w[15:8], o_table_high_byte);
	endtask : tbl
	// =====================================================================
	// scenarios
	task automatic t_reset();
		@(negedge i_clk);
		cmp("pc", 0, o_pc);
		cmp("rom_addr", 0, o_rom_addr);
		cmp("full", 0, o_stack_full);
	endtask : t_reset
	task automatic t_jump();
		issue(OP_JUMP, 13'h1234, 8'h00);
		cmp("pc", 18'h2_7234, o_pc);
		cmp("fetch", 0, o_fetch_valid);
		issue(OP_PCL_WR, 13'h0000, 8'h9C);
		cmp("pc", 18'h2_729C, o_pc);
		cmp("pcl", 8'h9C, o_pc_low_byte);
		@(posedge i_clk);
		i_cyc_en <= 1'b0;
		@(posedge i_clk);
		i_cyc_en <= 1'b1;
		#1;
		cmp("pc_hold", 18'h2_729C, o_pc);
	endtask : t_jump
	task automatic t_callret();
		logic [17:0] r;
		issue(OP_CALL, 13'h0ABC, 8'h00);
		r = pcs;
		cmp("pc", 18'h2_6ABC, o_pc);
		cmp("fetch", 0, o_fetch_valid);
		issue(OP_RET, 13'h0000, 8'h00);
		cmp("pc", r, o_pc);
		issue(OP_SKIP, 13'h0000, 8'h00, 1'b1);
		cmp("pc", pcs + 18'h0_0002, o_pc);
	endtask : t_callret
	task automatic t_alu();
		logic [7:0] h;
		h = o_table_high_byte;
		issue(OP_ALU, 13'h0000, 8'h00);
		for (int k = 0; k < 3 && o_dest_we !== 1'b1; k++) @(negedge i_clk);
		cmp("dest_we", 1, o_dest_we);
		cmp("dest", 8'hC3, o_dest_data);
		cmp("status", 4'h5, o_status);
		cmp("high", h, o_table_high_byte);
	endtask : t_alu
	task automatic t_irq();
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i);
			ack(VECS[i], 1'b1);
			cmp("flags", 0, o_irq_flags);
			issue(OP_ISR_EXIT, 13'h0000, 8'h00);
		end
	endtask : t_irq
	task automatic t_prio();
		@(posedge i_clk);
		i_global_en <= 1'b0;
		pulse(6'h28);
		@(posedge i_clk);
		i_global_en <= 1'b1;
		ack(VEC_TMR2, 1'b1);
		cmp("flags", 6'h20, o_irq_flags);
		ack(0, 1'b0);
		issue(OP_ISR_EXIT, 13'h0000, 8'h00);
		ack(VEC_ADPCM, 1'b1);
		issue(OP_ISR_EXIT, 13'h0000, 8'h00);
	endtask : t_prio
	task automatic t_full();
		for (int i = 0; i < 8; i++) issue(OP_CALL, 13'h0100, 8'h00);
		cmp("full", 1, o_stack_full);
		issue(OP_CALL, 13'h0200, 8'h00);
		cmp("pc", 18'h2_6200, o_pc);
		pulse(6'h04);
		ack(0, 1'b0);
		cmp("flags", 6'h04, o_irq_flags);
		issue(OP_RET, 13'h0000, 8'h00);
		ack(VEC_TMR1, 1'b1);
		issue(OP_ISR_EXIT, 13'h0000, 8'h00);
	endtask : t_full
	initial begin
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		t_reset();
		t_jump();
		t_callret();
		tbl(OP_TBL_CUR, 18'h2_B35A);
		tbl(OP_TBL_LAST, 18'h2_7F5A);
		t_alu();
		t_irq();
		t_prio();
		t_full();
		final_report();
	end
endmodule : tb
`default_nettype wire
